// ==== sim/hsw_switch_model.sv ====
// Switch device model driven by the select pins
`timescale 1ns/1ps
module hsw_switch_model (
  input wire logic port_select_a, // Select A
  input wire logic port_select_b, // Select B
  input wire logic cable_eq_select, // Long cable eq
  input wire logic sink_hotplug_in, // Sink hot-plug
  output logic [2:0] termOn, // Termination per port
  output logic [2:0] ddcLink, // DDC path per port
  output logic [2:0] hotplugOut, // Hot-plug per port
  output logic [2:0] eqLong, // Eq per port
  output logic outHiZ // Outputs released
);
  logic [2:0] pick;
  assign pick = {port_select_a & port_select_b, ~port_select_a & port_select_b,
    ~port_select_a & ~port_select_b};
  assign outHiZ = port_select_a & ~port_select_b;
  assign termOn = pick;
  assign ddcLink = pick;
  assign hotplugOut = outHiZ ? {3{sink_hotplug_in}} : pick & {3{sink_hotplug_in}};
  assign eqLong = {3{cable_eq_select}};
endmodule

// ==== sim/tb_hsw_select_ctrl.sv ====
// Self-checking bench for the select controller and switch model
`timescale 1ns/1ps
module tb_hsw_select_ctrl;
  logic clk_sys = 0, sys_rst = 1, reqValid = 0, reqLongCable = 0, addrWrEn = 0, hp = 0;
  logic [1:0] reqPort = 0, addrWrPort = 0, activePort;
  logic [15:0] addrWrData = 0, cecAddr;
  logic reqReady, selA, selB, eqSel, inStandby, cecAddrLoad, outHiZ;
  logic [2:0] termOn, ddcLink, hotplugOut, eqLong, oh;
  logic [15:0] tbl [4];
  logic [15:0] expAddr = 16'hffff;
  int fails = 0, tests_run = 0, seed = 97739, cyc = 0, n;
  always #20 clk_sys = ~clk_sys;
  hsw_select_ctrl i_hsw_select_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqReady(reqReady), .reqPort(reqPort),
    .reqLongCable(reqLongCable), .addrWrEn(addrWrEn), .addrWrPort(addrWrPort),
    .addrWrData(addrWrData), .port_select_a(selA), .port_select_b(selB),
    .cable_eq_select(eqSel), .activePort(activePort), .inStandby(inStandby),
    .cecAddr(cecAddr), .cecAddrLoad(cecAddrLoad));
  hsw_switch_model i_hsw_switch_model (.port_select_a(selA), .port_select_b(selB),
    .cable_eq_select(eqSel), .sink_hotplug_in(hp), .termOn(termOn), .ddcLink(ddcLink),
    .hotplugOut(hotplugOut), .eqLong(eqLong), .outHiZ(outHiZ));
  function logic [1:0] sc(input logic [1:0] p);
    return (p == 2'h0) ? 2'h2 : (p == 2'h1) ? 2'h0 : (p == 2'h2) ? 2'h1 : 2'h3;
  endfunction
  task chk(input logic [15:0] e, input logic [15:0] g, input string nm);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task run(input logic [1:0] p, input logic lc);
    @(posedge clk_sys);
    reqValid <= 1;
    reqPort <= p;
    reqLongCable <= lc;
    @(posedge clk_sys);
    reqValid <= 0;
    #1;
    chk(16'(expAddr != 16'hffff), cecAddrLoad, "withdraw");
    chk(16'hffff, cecAddr, "hidden");
    chk(16'h0, activePort, "noport");
    chk(16'h0, {reqReady, inStandby}, "busy");
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cecAddrLoad !== 1'b1 && n < 20);
    oh = (p == 2'h0) ? 3'h0 : 3'h1 << (p - 2'h1);
    chk(16'(hsw_pkg::SETTLE_CYC) + 16'h2, 16'(n), "latency");
    chk(16'(sc(p)), {selA, selB}, "pins");
    chk(16'(lc), eqSel, "eq");
    chk(16'(p), activePort, "port");
    chk(16'(p == 2'h0), inStandby, "standby");
    expAddr = (p == 2'h0) ? 16'hffff : tbl[p];
    chk(expAddr, cecAddr, "addr");
    chk(16'(oh), termOn, "term");
    chk(16'(oh), ddcLink, "ddc");
    chk(16'(p == 2'h0), outHiZ, "hiz");
    chk(16'({3{lc}}), eqLong, "eqall");
    repeat (2) begin
      @(posedge clk_sys);
      hp <= 1'($random(seed));
      #1;
      chk(16'((p == 2'h0) ? {3{hp}} : oh & {3{hp}}), hotplugOut, "hpd");
      chk(16'h2, {reqReady, cecAddrLoad}, "after");
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_sys);
      tbl[i] = 16'($random(seed));
      addrWrEn <= 1;
      addrWrPort <= 2'(i);
      addrWrData <= tbl[i];
    end
    @(posedge clk_sys);
    addrWrEn <= 0;
    #1;
    chk(16'h2, {selA, selB}, "rstpins");
    chk(16'hffff, cecAddr, "rstaddr");
    chk(16'h1, reqReady, "ready");
    run(2'h1, 1'b0);
    run(2'h1, 1'b1);
    run(2'h0, 1'b0);
    run(2'h0, 1'b1);
    run(2'h3, 1'b1);
    run(2'h2, 1'b0);
    repeat (30) run(2'($random(seed)), 1'($random(seed)));
    report_and_stop();
  end
endmodule

// ==== verilog/hsw_addr_mem.sv ====
// Small table holding the address to load for each source port
`timescale 1ns/1ps
module hsw_addr_mem
  import hsw_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic wrEn, // Write strobe
  input wire logic [1:0] wrPort, // Port written
  input wire logic [15:0] wrData, // Address written
  input wire logic [1:0] rdPort, // Port read
  output logic [15:0] rdData // Registered read data
);
  typedef struct packed {
    logic [3:0][15:0] word;
    logic [15:0] rd;
  } hsw_mem_s;

  hsw_mem_s m_q, m_d;

  // Read sees the old word when the same entry is written in that cycle
  always_comb begin
    m_d = m_q;
    if (wrEn) begin
      m_d.word[wrPort] = wrData;
    end
    m_d.rd = (rdPort == PORT_NONE) ? CEC_ADDR_INVALID : m_q.word[rdPort];
  end

  always_ff @(posedge clk_sys) begin
    m_q <= m_d;
  end

  assign rdData = m_q.rd;
endmodule

// ==== verilog/hsw_pkg.sv ====
// Package with select encodings and timing counts for the switch select controller
package hsw_pkg;
  // Select pin codes {port_select_a, port_select_b}
  localparam logic [1:0] SEL_PORT1 = 2'h0;
  localparam logic [1:0] SEL_PORT2 = 2'h1;
  localparam logic [1:0] SEL_STANDBY = 2'h2;
  localparam logic [1:0] SEL_PORT3 = 2'h3;
  // Port index codes used on the command port
  localparam logic [1:0] PORT_NONE = 2'h0;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;
  localparam logic [1:0] PORT_THREE = 2'h3;
  // Select-to-switch settle time, longest of the documented switch times
  localparam int SETTLE_NS = 250;
  localparam int CLK_NS = 40;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // Address of an unaddressed source, all ones
  localparam logic [15:0] CEC_ADDR_INVALID = 16'hffff;
  localparam logic [15:0] CEC_ADDR_RST = 16'hffff;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DRIVE = 4'h2,
    ST_SETTLE = 4'h4,
    ST_LOAD = 4'h8
  } hsw_state_e;
endpackage

// ==== verilog/hsw_select_ctrl.sv ====
// Controller driving the select and equalization pins of a three-to-one HDMI switch
`timescale 1ns/1ps
module hsw_select_ctrl
  import hsw_pkg::*;
(
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic reqValid, // New port request
  output logic reqReady, // Request can be taken
  input wire logic [1:0] reqPort, // 0 standby, 1..3 source port
  input wire logic reqLongCable, // Long cable equalization wanted
  input wire logic addrWrEn, // Write an address table entry
  input wire logic [1:0] addrWrPort, // Entry port 1..3
  input wire logic [15:0] addrWrData, // Physical address for that port
  output logic port_select_a, // Select pin A to switch
  output logic port_select_b, // Select pin B to switch
  output logic cable_eq_select, // Equalization pin, high for long cable
  output logic [1:0] activePort, // Port now settled, 0 in standby
  output logic inStandby, // Switch settled in standby
  output logic [15:0] cecAddr, // Physical address loaded for the CEC logic
  output logic cecAddrLoad // One-cycle pulse when cecAddr is withdrawn or reloaded, also for standby
);
  // All controller state, registered as one copy
  typedef struct packed {
    hsw_state_e st;
    logic [1:0] port;
    logic [1:0] sel;
    logic eq;
    logic [3:0] cnt;
    logic [1:0] active;
    logic [15:0] addr;
    logic load;
    logic stby;
  } hsw_s;

  hsw_s r_q, r_d;
  logic [15:0] memData;

  // Port to pin code; standby is A high, B low
  function automatic logic [1:0] port2sel(input logic [1:0] p);
    case (p)
      PORT_ONE: port2sel = SEL_PORT1;
      PORT_TWO: port2sel = SEL_PORT2;
      PORT_THREE: port2sel = SEL_PORT3;
      default: port2sel = SEL_STANDBY;
    endcase
  endfunction

  // Pin code back to port, used by the checks on what the pins really show
  function automatic logic [1:0] sel2port(input logic [1:0] s);
    case (s)
      SEL_PORT1: sel2port = PORT_ONE;
      SEL_PORT2: sel2port = PORT_TWO;
      SEL_PORT3: sel2port = PORT_THREE;
      default: sel2port = PORT_NONE;
    endcase
  endfunction

  hsw_addr_mem uMem (
    .clk_sys(clk_sys),
    .wrEn(addrWrEn),
    .wrPort(addrWrPort),
    .wrData(addrWrData),
    .rdPort(r_q.port),
    .rdData(memData)
  );

  always_comb begin
    r_d = r_q;
    r_d.load = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        if (reqValid) begin
          r_d.port = reqPort;
          r_d.eq = reqLongCable;
          r_d.st = ST_DRIVE;
          // Address withdrawn at once, so no source keeps a stale one while pins move
          r_d.active = PORT_NONE;
          r_d.addr = CEC_ADDR_INVALID;
          r_d.load = (r_q.addr != CEC_ADDR_INVALID);
        end
      end
      ST_DRIVE: begin
        r_d.sel = port2sel(r_q.port);
        // Pins hold for the settle time so the chosen hot-plug is valid first
        r_d.cnt = SETTLE_CYC;
        r_d.st = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (r_q.cnt <= 4'h1) begin
          r_d.st = ST_LOAD;
        end else begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      ST_LOAD: begin
        r_d.active = r_q.port;
        r_d.addr = memData;
        r_d.load = 1'b1;
        r_d.st = ST_IDLE;
      end
      default: r_d.st = ST_IDLE;
    endcase
    r_d.stby = (r_d.st == ST_IDLE) && (r_d.active == PORT_NONE);
  end

  always_ff @(posedge clk_sys) begin
    // Reset leaves the switch in standby with no address shown
    if (sys_rst) begin
      r_q <= '{st: ST_IDLE, port: PORT_NONE, sel: SEL_STANDBY, eq: 1'b0, cnt: 4'h0,
               active: PORT_NONE, addr: CEC_ADDR_RST, load: 1'b0, stby: 1'b1};
    end else begin
      r_q <= r_d;
    end
  end

  // A busy controller holds requests off; the caller keeps reqValid up
  assign reqReady = (r_q.st == ST_IDLE);
  assign port_select_a = r_q.sel[1];
  assign port_select_b = r_q.sel[0];
  assign cable_eq_select = r_q.eq;
  assign activePort = r_q.active;
  assign inStandby = r_q.stby;
  assign cecAddr = r_q.addr;
  assign cecAddrLoad = r_q.load;

  a_sel_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_LOAD) |-> (r_q.sel == port2sel(r_q.port)))
    else $error("select pins do not match chosen port");
  a_standby_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_LOAD && r_q.port == PORT_NONE) |-> (port_select_a && !port_select_b))
    else $error("standby code wrong");
  sequence s_req;
    reqValid && reqReady;
  endsequence
  sequence s_done;
    ##(1 + 1 + 7) (r_q.st == ST_LOAD) ##1 cecAddrLoad;
  endsequence
  a_addr_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |-> s_done)
    else $error("address not reloaded after port change");
  a_eq_apply: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> (cable_eq_select == $past(reqLongCable)))
    else $error("equalization not applied");
  a_addr_invalid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> (cecAddr == CEC_ADDR_INVALID) && (activePort == PORT_NONE))
    else $error("address kept during switch");

  // Steps of one switch as seen on the outputs
  sequence s_busy;
    (!reqReady) [*8] ##1 !reqReady;
  endsequence
  sequence s_hidden;
    (activePort == PORT_NONE) [*8] ##1 (activePort == PORT_NONE);
  endsequence
  sequence s_withdraw;
    s_req ##1 cecAddrLoad;
  endsequence

  a_busy_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> s_busy ##1 reqReady)
    else $error("ready not held low for the whole switch");
  a_pins_late: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> $stable({port_select_a, port_select_b})
      ##1 ({port_select_a, port_select_b} == port2sel($past(reqPort, 2))))
    else $error("select pins moved at the wrong time");
  a_pins_still: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_SETTLE) |=> $stable({port_select_a, port_select_b}))
    else $error("select pins moved while settling");
  a_pins_move: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st != ST_DRIVE) |=> $stable({port_select_a, port_select_b}))
    else $error("select pins moved outside a switch");

  a_active_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> s_hidden ##1 (activePort == $past(reqPort, 10)))
    else $error("port reported before the pins settled");
  a_addr_hide: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (activePort == PORT_NONE) |-> (cecAddr == CEC_ADDR_INVALID))
    else $error("address shown with no port chosen");
  a_addr_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> (cecAddrLoad == ($past(cecAddr) != CEC_ADDR_INVALID)))
    else $error("address withdrawal not signalled");
  a_load_short: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_withdraw |=> !cecAddrLoad)
    else $error("withdrawal pulse too long");
  a_load_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_LOAD) |=> cecAddrLoad && (cecAddr == $past(memData)))
    else $error("loaded address differs from table");
  a_load_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cecAddrLoad |-> (r_q.st == ST_DRIVE) || (r_q.st == ST_IDLE))
    else $error("address pulse outside a switch step");

  a_eq_steady: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(reqValid && reqReady) |=> $stable(cable_eq_select))
    else $error("equalization changed without a request");
  a_standby_pins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    inStandby |-> (sel2port({port_select_a, port_select_b}) == PORT_NONE))
    else $error("standby reported with a port selected");
  a_stby_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_req |=> ##9 (inStandby == ($past(reqPort, 10) == PORT_NONE)))
    else $error("standby flag wrong after a switch");
  a_port_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st != ST_IDLE) |=> (r_q.port == $past(r_q.port)))
    else $error("chosen port changed during a switch");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_IDLE) && !reqValid |=> $stable(cecAddr) && $stable(activePort))
    else $error("outputs changed while idle");

  a_count_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_SETTLE) |-> (r_q.cnt != 4'h0) && (r_q.cnt <= SETTLE_CYC))
    else $error("settle count out of range");
  a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_q.st == ST_SETTLE) && (r_q.cnt > 4'h1) |=>
      (r_q.st == ST_SETTLE) && (r_q.cnt == $past(r_q.cnt) - 4'h1))
    else $error("settle count skipped a step");

  // One check per source port: a reported port must be the one the pins select
  for (genvar g = 1; g < 4; g++) begin : g_port
    a_port_pins: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (activePort == 2'(g)) |-> (sel2port({port_select_a, port_select_b}) == 2'(g)))
      else $error("reported port differs from select pins");
  end
endmodule
